// *** gfp_port.sv ***
// Operation
// - Five general purpose pins, 0 to 4, each input or output.
// - Direction is set separately for every pin.
// - While reset is low, pin 0 has input buffer and pull-up enabled.
// - Pin 0 high at reset release selects normal boot from flash.
// - Pin 0 low at reset release selects single boot from boot program.
// - After reset all pins are plain port, every enable off.
// - Data register at offset 0x0, output enable at 0x4.
// - Function select registers at 0x8, 0xC and 0x10.
// - Open-drain, pull-up, pull-down registers at 0x28, 0x2C, 0x30.
// - Input enable at 0x38; gaps between registers are unmapped.
// - Data register bits 4 to 0 read/write, bits 31 to 5 read zero.
// - Output enable bit one turns the pin driver on; upper bits zero.
// - Function one bits 4, 3, 2 route encoder phases Z, B, A.
// - Function one bit 1 drives timer output, bit 0 feeds timer input.
// - Function two bits 4, 3, 2 give serial receive, transmit, clock.
// - Function three has only bit 2: serial clear-to-send on pin 2.
// - Open-drain bit one makes the pin open drain, else push-pull.
// - Input, pull-up and pull-down bits enable their pad features.
//
// The APB interface to the registers was decided locally.
`timescale 1ns/1ps
`default_nettype none

module gfp_port (
	input  wire logic                      pclk,
	input  wire logic                      presetn,
	input  wire logic                      psel,
	input  wire logic                      penable,
	input  wire logic                      pwrite,
	input  wire logic [11:0]               paddr,
	input  wire logic [31:0]               pwdata,
	output var  logic [31:0]               prdata,
	output var  logic                      pready,
	output var  logic                      pslverr,
	input  wire logic [4:0]                pin_i,
	output var  gfp_pkg::gfp_pad_t         pad,
	input  wire gfp_pkg::gfp_periph_out_t  per_from,
	output var  gfp_pkg::gfp_periph_in_t   per_to,
	output var  logic                      boot_done,
	output var  logic                      boot_from_flash
);

	gfp_pkg::gfp_state_t state_q;
	gfp_pkg::gfp_state_t state_d;
	logic [4:0]          alt_en;
	logic [4:0]          alt_val;
	logic [4:0]          alt_oe;
	logic [4:0]          drv_val;
	logic [4:0]          drv_oe;
	logic [4:0]          pad_o_n;
	logic [4:0]          pad_oe_n;
	logic [4:0]          pin_in;
	logic                setup;
	logic                wr_take;
	logic                hit;
	logic [4:0]          rd_val;

	// Alternate output functions per pin; only pins 1, 2 and 3 have one.
	assign alt_en  = {1'b0, state_q.regs.fs2[gfp_pkg::GFP_BIT_SIO_TX], state_q.regs.fs2[gfp_pkg::GFP_BIT_SIO_CLK],
			state_q.regs.fs1[gfp_pkg::GFP_BIT_TMR_OUT], 1'b0};
	assign alt_val = {1'b0, per_from.sio_tx, per_from.sio_clk, per_from.tmr_out, 1'b0};
	assign alt_oe  = {state_q.regs.oe[4], state_q.regs.oe[3], per_from.sio_clk_oe, state_q.regs.oe[1],
			state_q.regs.oe[0]};

	// Conditioned pin level; an input with its buffer off reads as zero.
	assign pin_in = state_q.filt & state_q.regs.ie;

	// Per pin driver: source select, then open-drain or push-pull shaping.
	generate
		for (genvar k = 0; k < gfp_pkg::GFP_PINS; k++)
		begin : g_pin
			assign drv_val[k]  = alt_en[k] ? alt_val[k] : state_q.regs.data[k];
			assign drv_oe[k]   = alt_en[k] ? alt_oe[k] : state_q.regs.oe[k];
			// An open-drain pin only ever drives low and releases for a one.
			assign pad_o_n[k]  = state_q.regs.od[k] ? 1'b0 : drv_val[k];
			assign pad_oe_n[k] = drv_oe[k] & (~state_q.regs.od[k] | ~drv_val[k]);
		end
	endgenerate

	// Bus phase decode: setup prepares the answer, access commits writes.
	assign setup   = psel & ~penable;
	assign wr_take = psel & penable & state_q.pready & pwrite & ~state_q.pslverr;

	// Read mux and address decode; unlisted offsets are errors.
	always_comb
	begin
		hit    = 1'b1;
		rd_val = gfp_pkg::GFP_REG_RST;
		case (paddr)
			gfp_pkg::GFP_OFS_DATA: rd_val = pin_in;
			gfp_pkg::GFP_OFS_OE:   rd_val = state_q.regs.oe;
			gfp_pkg::GFP_OFS_FS1:  rd_val = state_q.regs.fs1;
			gfp_pkg::GFP_OFS_FS2:  rd_val = state_q.regs.fs2;
			gfp_pkg::GFP_OFS_FS3:  rd_val = state_q.regs.fs3;
			gfp_pkg::GFP_OFS_OD:   rd_val = state_q.regs.od;
			gfp_pkg::GFP_OFS_PU:   rd_val = state_q.regs.pu;
			gfp_pkg::GFP_OFS_PD:   rd_val = state_q.regs.pd;
			gfp_pkg::GFP_OFS_IE:   rd_val = state_q.regs.ie;
			default:               hit    = 1'b0;
		endcase
	end

	// Next state of the whole block.
	always_comb
	begin
		state_d = state_q;

		// Three-stage synchroniser; a change counts when stages two and three agree.
		state_d.s1   = pin_i;
		state_d.s2   = state_q.s1;
		state_d.s3   = state_q.s2;
		state_d.filt = ((state_q.s2 ~^ state_q.s3) & state_q.s2) | ((state_q.s2 ^ state_q.s3) & state_q.filt);

		// Bus answer is ready in the first access cycle, so no wait states.
		state_d.pready  = setup;
		state_d.pslverr = setup & ~hit;
		state_d.prdata  = '0;
		if (setup && !pwrite && hit)
		begin
			state_d.prdata = {gfp_pkg::GFP_RD_ZERO, rd_val};
		end

		// Register writes; unimplemented bits are never stored so they read zero.
		if (wr_take)
		begin
			case (paddr)
				gfp_pkg::GFP_OFS_DATA: state_d.regs.data = pwdata[4:0] & gfp_pkg::GFP_MASK_ALL;
				gfp_pkg::GFP_OFS_OE:   state_d.regs.oe   = pwdata[4:0] & gfp_pkg::GFP_MASK_ALL;
				gfp_pkg::GFP_OFS_FS1:  state_d.regs.fs1  = pwdata[4:0] & gfp_pkg::GFP_MASK_ALL;
				gfp_pkg::GFP_OFS_FS2:  state_d.regs.fs2  = pwdata[4:0] & gfp_pkg::GFP_MASK_FS2;
				gfp_pkg::GFP_OFS_FS3:  state_d.regs.fs3  = pwdata[4:0] & gfp_pkg::GFP_MASK_FS3;
				gfp_pkg::GFP_OFS_OD:   state_d.regs.od   = pwdata[4:0] & gfp_pkg::GFP_MASK_ALL;
				gfp_pkg::GFP_OFS_PU:   state_d.regs.pu   = pwdata[4:0] & gfp_pkg::GFP_MASK_ALL;
				gfp_pkg::GFP_OFS_PD:   state_d.regs.pd   = pwdata[4:0] & gfp_pkg::GFP_MASK_ALL;
				gfp_pkg::GFP_OFS_IE:   state_d.regs.ie   = pwdata[4:0] & gfp_pkg::GFP_MASK_ALL;
				default:               state_d.regs      = state_q.regs;
			endcase
		end

		// Pad controls follow the registers once the boot pin has been read.
		state_d.pad.o  = pad_o_n;
		state_d.pad.oe = pad_oe_n;
		state_d.pad.pu = state_q.regs.pu;
		state_d.pad.pd = state_q.regs.pd;
		state_d.pad.ie = state_q.regs.ie;

		// Peripheral inputs see the conditioned pin only while selected.
		state_d.per.tmr_in  = state_q.regs.fs1[gfp_pkg::GFP_BIT_TMR_IN] & pin_in[gfp_pkg::GFP_BIT_TMR_IN];
		state_d.per.enc_a   = state_q.regs.fs1[gfp_pkg::GFP_BIT_ENC_A] & pin_in[gfp_pkg::GFP_BIT_ENC_A];
		state_d.per.enc_b   = state_q.regs.fs1[gfp_pkg::GFP_BIT_ENC_B] & pin_in[gfp_pkg::GFP_BIT_ENC_B];
		state_d.per.enc_z   = state_q.regs.fs1[gfp_pkg::GFP_BIT_ENC_Z] & pin_in[gfp_pkg::GFP_BIT_ENC_Z];
		state_d.per.sio_rx  = state_q.regs.fs2[gfp_pkg::GFP_BIT_SIO_RX] & pin_in[gfp_pkg::GFP_BIT_SIO_RX];
		state_d.per.sio_clk = state_q.regs.fs2[gfp_pkg::GFP_BIT_SIO_CLK] & pin_in[gfp_pkg::GFP_BIT_SIO_CLK];
		state_d.per.sio_cts = state_q.regs.fs3[gfp_pkg::GFP_BIT_SIO_CTS] & pin_in[gfp_pkg::GFP_BIT_SIO_CTS];

		// The boot pin keeps its pull-up and buffer until the synchroniser is full.
		// The raw pin is never sampled directly, which costs five cycles after release.
		unique case (state_q.boot)
			gfp_pkg::GFP_BOOT_SYNC:
			begin
				state_d.pad.pu = state_q.regs.pu | gfp_pkg::GFP_BOOT_PIN;
				state_d.pad.ie = state_q.regs.ie | gfp_pkg::GFP_BOOT_PIN;
				state_d.cnt    = state_q.cnt + gfp_pkg::GFP_CNT_ONE;
				if (state_q.cnt == gfp_pkg::GFP_BOOT_WAIT)
				begin
					state_d.flash = state_q.filt[0];
					// Forcing ends with the capture, so the pads match the registers once boot_done is seen.
					state_d.pad.pu = state_q.regs.pu;
					state_d.pad.ie = state_q.regs.ie;
					state_d.done  = 1'b1;
					state_d.boot  = gfp_pkg::GFP_BOOT_RUN;
				end
			end
			gfp_pkg::GFP_BOOT_RUN:
			begin
				state_d.cnt = state_q.cnt;
			end
			default:
			begin
				state_d.boot = gfp_pkg::GFP_BOOT_SYNC;
			end
		endcase
	end

	// State register; reset holds only the boot pin's pull-up and buffer on.
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			state_q        <= '0;
			state_q.pad.pu <= gfp_pkg::GFP_BOOT_PIN;
			state_q.pad.ie <= gfp_pkg::GFP_BOOT_PIN;
			state_q.boot   <= gfp_pkg::GFP_BOOT_SYNC;
		end
		else
		begin
			state_q <= state_d;
		end
	end

	// Every output is a flip-flop of the state.
	assign prdata          = state_q.prdata;
	assign pready          = state_q.pready;
	assign pslverr         = state_q.pslverr;
	assign pad             = state_q.pad;
	assign per_to          = state_q.per;
	assign boot_done       = state_q.done;
	assign boot_from_flash = state_q.flash;

	default clocking cb @(posedge pclk);
	endclocking
	default disable iff (!presetn);

	sequence s_read(logic [11:0] a);
		psel && !penable && !pwrite && paddr == a;
	endsequence

	sequence s_write(logic [11:0] a);
		psel && penable && pready && pwrite && !pslverr && paddr == a;
	endsequence

	property p_boot_pin_held;
		!boot_done |-> pad.pu[0] && pad.ie[0];
	endproperty
	a_boot_pin_held: assert property (p_boot_pin_held) else $error("Boot pin lost pull-up or buffer.");

	property p_boot_flash;
		$rose(boot_done) && $past(state_q.filt[0]) |-> boot_from_flash;
	endproperty
	a_boot_flash: assert property (p_boot_flash) else $error("High boot pin did not select flash.");

	property p_boot_rom;
		$rose(boot_done) && !$past(state_q.filt[0]) |-> !boot_from_flash ##1 !boot_from_flash;
	endproperty
	a_boot_rom: assert property (p_boot_rom) else $error("Low boot pin did not select boot program.");

	property p_reset_quiet;
		!boot_done && state_q.cnt == 3'h1 |-> pad.oe == 5'h00 && pad.pd == 5'h00 && pad.pu[4:1] == 4'h0;
	endproperty
	a_reset_quiet: assert property (p_reset_quiet) else $error("Pad enabled straight after reset.");

	property p_unmapped;
		psel && !penable && !hit |=> pready && pslverr && prdata == 32'h00000000;
	endproperty
	a_unmapped: assert property (p_unmapped) else $error("Unmapped offset not refused.");

	property p_oe_readback;
		s_write(gfp_pkg::GFP_OFS_OE) ##2 s_read(gfp_pkg::GFP_OFS_OE)
			|=> prdata[4:0] == $past(pwdata[4:0], 3) && prdata[31:5] == 27'h0000000;
	endproperty
	a_oe_readback: assert property (p_oe_readback) else $error("Output enable read-back wrong.");

	property p_data_read;
		s_read(gfp_pkg::GFP_OFS_DATA) |=> prdata == {27'h0000000, $past(state_q.filt & state_q.regs.ie)};
	endproperty
	a_data_read: assert property (p_data_read) else $error("Data read not gated pin level.");

	property p_fs3_mask;
		s_read(gfp_pkg::GFP_OFS_FS3) |=> (prdata & 32'hFFFFFFFB) == 32'h00000000;
	endproperty
	a_fs3_mask: assert property (p_fs3_mask) else $error("Function three has extra bits.");

	property p_encoder_a;
		state_q.regs.fs1[2] && state_q.regs.ie[2] |=> per_to.enc_a == $past(state_q.filt[2]);
	endproperty
	a_encoder_a: assert property (p_encoder_a) else $error("Encoder phase A not routed.");

	property p_timer_out;
		state_q.regs.fs1[1] && !state_q.regs.od[1] |=> pad.o[1] == $past(per_from.tmr_out) &&
			pad.oe[1] == $past(state_q.regs.oe[1]);
	endproperty
	a_timer_out: assert property (p_timer_out) else $error("Timer output not on pin 1.");

	property p_serial_tx;
		state_q.regs.fs2[3] && !state_q.regs.od[3] |=> pad.o[3] == $past(per_from.sio_tx);
	endproperty
	a_serial_tx: assert property (p_serial_tx) else $error("Serial transmit not on pin 3.");

	property p_open_drain;
		state_q.regs.od[4] |=> !pad.o[4] && (pad.oe[4] == $past(state_q.regs.oe[4] & ~state_q.regs.data[4]));
	endproperty
	a_open_drain: assert property (p_open_drain) else $error("Open-drain pin drove high.");

	property p_ie_follow;
		boot_done |=> pad.ie == $past(state_q.regs.ie) && pad.pd == $past(state_q.regs.pd);
	endproperty
	a_ie_follow: assert property (p_ie_follow) else $error("Pad enables do not follow registers.");

endmodule : gfp_port

`default_nettype wire

// *** gfp_pkg.sv ***
`default_nettype none

package gfp_pkg;

	// Port width and register offsets from the port base.
	localparam int unsigned GFP_PINS        = 5;
	localparam logic [11:0] GFP_OFS_DATA    = 12'h000;
	localparam logic [11:0] GFP_OFS_OE      = 12'h004;
	localparam logic [11:0] GFP_OFS_FS1     = 12'h008;
	localparam logic [11:0] GFP_OFS_FS2     = 12'h00C;
	localparam logic [11:0] GFP_OFS_FS3     = 12'h010;
	localparam logic [11:0] GFP_OFS_OD      = 12'h028;
	localparam logic [11:0] GFP_OFS_PU      = 12'h02C;
	localparam logic [11:0] GFP_OFS_PD      = 12'h030;
	localparam logic [11:0] GFP_OFS_IE      = 12'h038;

	// Implemented bits per register and reset values.
	localparam logic [4:0]  GFP_MASK_ALL    = 5'h1F;
	localparam logic [4:0]  GFP_MASK_FS2    = 5'h1C;
	localparam logic [4:0]  GFP_MASK_FS3    = 5'h04;
	localparam logic [4:0]  GFP_REG_RST     = 5'h00;
	localparam logic [4:0]  GFP_BOOT_PIN    = 5'h01;
	localparam logic [26:0] GFP_RD_ZERO     = 27'h0000000;

	// Pin positions of the alternate functions.
	localparam int unsigned GFP_BIT_TMR_IN  = 0;
	localparam int unsigned GFP_BIT_TMR_OUT = 1;
	localparam int unsigned GFP_BIT_ENC_A   = 2;
	localparam int unsigned GFP_BIT_ENC_B   = 3;
	localparam int unsigned GFP_BIT_ENC_Z   = 4;
	localparam int unsigned GFP_BIT_SIO_CLK = 2;
	localparam int unsigned GFP_BIT_SIO_TX  = 3;
	localparam int unsigned GFP_BIT_SIO_RX  = 4;
	localparam int unsigned GFP_BIT_SIO_CTS = 2;

	// Edges after reset release before the boot pin is trusted.
	localparam logic [2:0]  GFP_BOOT_WAIT   = 3'h4;
	localparam logic [2:0]  GFP_CNT_ONE     = 3'h1;

	typedef enum logic [1:0] {
		GFP_BOOT_SYNC = 2'b01,
		GFP_BOOT_RUN  = 2'b10
	} gfp_boot_t;

	typedef struct packed {
		logic [4:0] data;
		logic [4:0] oe;
		logic [4:0] fs1;
		logic [4:0] fs2;
		logic [4:0] fs3;
		logic [4:0] od;
		logic [4:0] pu;
		logic [4:0] pd;
		logic [4:0] ie;
	} gfp_regs_t;

	typedef struct packed {
		logic [4:0] o;
		logic [4:0] oe;
		logic [4:0] pu;
		logic [4:0] pd;
		logic [4:0] ie;
	} gfp_pad_t;

	typedef struct packed {
		logic enc_a;
		logic enc_b;
		logic enc_z;
		logic tmr_in;
		logic sio_rx;
		logic sio_clk;
		logic sio_cts;
	} gfp_periph_in_t;

	typedef struct packed {
		logic tmr_out;
		logic sio_tx;
		logic sio_clk;
		logic sio_clk_oe;
	} gfp_periph_out_t;

	typedef struct packed {
		gfp_regs_t      regs;
		logic [4:0]     s1;
		logic [4:0]     s2;
		logic [4:0]     s3;
		logic [4:0]     filt;
		gfp_pad_t       pad;
		gfp_periph_in_t per;
		logic [31:0]    prdata;
		logic           pready;
		logic           pslverr;
		gfp_boot_t      boot;
		logic [2:0]     cnt;
		logic           done;
		logic           flash;
	} gfp_state_t;

endpackage : gfp_pkg

`default_nettype wire

// *** gfp_board.sv ***
`timescale 1ns/1ps
`default_nettype none

// Board side of the port: an optional driver per pin, the pad resistors and floating pins.
module gfp_board (
	input  wire logic              pclk,
	input  wire gfp_pkg::gfp_pad_t pad,
	input  wire logic [4:0]        drv_en,
	input  wire logic [4:0]        drv_val,
	output var  logic [4:0]        pin_o
);
	logic [4:0] last_q;

	// A floating pin shows the inverse of its last level, so a stale read cannot pass by luck.
	always_comb
	begin
		for (int k = 0; k < 5; k++)
		begin
			if (pad.oe[k])
				pin_o[k] = pad.o[k];
			else if (drv_en[k])
				pin_o[k] = drv_val[k];
			else if (pad.pu[k])
				pin_o[k] = 1'b1;
			else if (pad.pd[k])
				pin_o[k] = 1'b0;
			else
				pin_o[k] = (last_q[k] === 1'b1) ? 1'b0 : 1'b1;
		end
	end

	// The last level is remembered once a cycle.
	always_ff @(posedge pclk)
	begin
		last_q <= pin_o;
	end
endmodule : gfp_board

`default_nettype wire

// *** five_bit_gpio_port_with_boot_pin_tb_top.sv ***
`timescale 1ns/1ps
`default_nettype none

module five_bit_gpio_port_with_boot_pin_tb_top;
	logic                     pclk;
	logic                     presetn;
	logic                     psel;
	logic                     penable;
	logic                     pwrite;
	logic [11:0]              paddr;
	logic [31:0]              pwdata;
	logic [31:0]              prdata;
	logic                     pready;
	logic                     pslverr;
	logic [4:0]               pin_i;
	gfp_pkg::gfp_pad_t        pad;
	gfp_pkg::gfp_periph_out_t per_from;
	gfp_pkg::gfp_periph_in_t  per_to;
	logic                     boot_done;
	logic                     boot_from_flash;
	logic [4:0]               drv_en;
	logic [4:0]               drv_val;
	int                       fail_count;
	int                       n_checks;
	logic [31:0]              rd;
	logic                     err;
	logic [11:0]              ofs [9];
	logic [4:0]               msk [9];

	gfp_port uut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
		.paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .pin_i(pin_i),
		.pad(pad), .per_from(per_from), .per_to(per_to), .boot_done(boot_done), .boot_from_flash(boot_from_flash));
	gfp_board board (.pclk(pclk), .pad(pad), .drv_en(drv_en), .drv_val(drv_val), .pin_o(pin_i));

	// Clock at 40 MHz.
	initial
	begin
		pclk = 1'b0;
		forever #12.5 pclk = ~pclk;
	end

	task automatic test_done;
		$display("checks %0d mismatches %0d", n_checks, fail_count);
		if (fail_count == 0 && n_checks > 0)
			$display("ALL TESTS PASSED");
		else
			$display("TESTS FAILED");
		$finish;
	endtask : test_done

	task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
		n_checks++;
		if (got !== exp)
		begin
			$display("BAD %s expected %h seen %h", what, exp, got);
			fail_count++;
		end
	endtask : chk

	// One APB transfer; the request is held until pready is seen high at a rising edge.
	task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d, output logic [31:0] r,
		output logic e);
		int n;
		@(posedge pclk);
		psel    <= 1'b1;
		penable <= 1'b0;
		pwrite  <= w;
		paddr   <= a;
		pwdata  <= d;
		@(posedge pclk);
		penable <= 1'b1;
		n = 0;
		do
		begin
			@(posedge pclk);
			n++;
		end
		while (pready !== 1'b1 && n < 20);
		r = prdata;
		e = pslverr;
		psel    <= 1'b0;
		penable <= 1'b0;
	endtask : apb

	task automatic wr(input logic [11:0] a, input logic [31:0] d);
		apb(1'b1, a, d, rd, err);
	endtask : wr

	task automatic rd_chk(input logic [11:0] a, input logic [31:0] exp);
		apb(1'b0, a, 32'h00000000, rd, err);
		chk("read data", exp, rd);
		chk("read error", 32'h00000000, {31'h0, err});
	endtask : rd_chk

	// Pin inputs pass a filter of several edges before they are visible.
	task automatic settle;
		repeat (6) @(posedge pclk);
		#1;
	endtask : settle

	// Reset with the boot pin either floating on its pull-up or held low by the board.
	task automatic do_reset(input logic pin0_low);
		int n;
		@(posedge pclk);
		presetn <= 1'b0;
		drv_en  <= {4'h0, pin0_low};
		drv_val <= 5'h00;
		repeat (2) @(posedge pclk);
		#1;
		chk("pad in reset", {7'h0, 5'h00, 5'h00, 5'h01, 5'h00, 5'h01}, {7'h0, pad});
		chk("ready and boot in reset", 32'h0, {30'h0, pready, boot_done});
		@(posedge pclk);
		presetn <= 1'b1;
		n = 0;
		while (boot_done !== 1'b1 && n < 20)
		begin
			@(posedge pclk);
			n++;
		end
		#1;
		chk("boot done", 32'h1, {31'h0, boot_done});
		chk("boot from flash", {31'h0, ~pin0_low}, {31'h0, boot_from_flash});
		chk("pull and input after boot", 32'h0, {22'h0, pad.pu, pad.ie});
		drv_en <= 5'h00;
		$display("test boot done");
	endtask : do_reset

	initial
	begin
		#100000;
		fail_count++;
		test_done();
	end

	initial
	begin
		presetn = 1'b0;
		psel = 1'b0;
		penable = 1'b0;
		pwrite = 1'b0;
		paddr = 12'h000;
		pwdata = 32'h0;
		per_from = 4'h0;
		drv_en = 5'h00;
		drv_val = 5'h00;
		fail_count = 0;
		n_checks = 0;
		ofs = '{gfp_pkg::GFP_OFS_DATA, gfp_pkg::GFP_OFS_OE, gfp_pkg::GFP_OFS_FS1, gfp_pkg::GFP_OFS_FS2,
			gfp_pkg::GFP_OFS_FS3, gfp_pkg::GFP_OFS_OD, gfp_pkg::GFP_OFS_PU, gfp_pkg::GFP_OFS_PD, gfp_pkg::GFP_OFS_IE};
		msk = '{5'h1F, 5'h1F, 5'h1F, 5'h1C, 5'h04, 5'h1F, 5'h1F, 5'h1F, 5'h1F};
		do_reset(1'b0);
		do_reset(1'b1);
		// Reset values, then every register except the data register written with all ones and cleared before the next.
		for (int i = 0; i < 9; i++)
			rd_chk(ofs[i], 32'h0);
		for (int i = 1; i < 9; i++)
		begin
			wr(ofs[i], 32'hFFFFFFFF);
			rd_chk(ofs[i], {27'h0, msk[i]});
			wr(ofs[i], 32'h0);
		end
		$display("test registers done");
		apb(1'b0, 12'h014, 32'h0, rd, err);
		chk("gap read error", 32'h1, {31'h0, err});
		chk("gap read data", 32'h0, rd);
		apb(1'b1, 12'h034, 32'hFFFFFFFF, rd, err);
		chk("gap write error", 32'h1, {31'h0, err});
		apb(1'b0, 12'h002, 32'h0, rd, err);
		chk("unaligned error", 32'h1, {31'h0, err});
		$display("test unmapped done");
		wr(gfp_pkg::GFP_OFS_OE, 32'h0000000A);
		wr(gfp_pkg::GFP_OFS_DATA, 32'hFFFFFF1B);
		settle();
		chk("pin drivers", 32'h0A, {27'h0, pad.oe});
		chk("pin levels", 32'h0A, {27'h0, pad.o & 5'h0A});
		wr(gfp_pkg::GFP_OFS_OE, 32'h0);
		wr(gfp_pkg::GFP_OFS_IE, 32'h1F);
		drv_en <= 5'h1F;
		drv_val <= 5'h15;
		settle();
		rd_chk(gfp_pkg::GFP_OFS_DATA, 32'h15);
		wr(gfp_pkg::GFP_OFS_IE, 32'h03);
		settle();
		rd_chk(gfp_pkg::GFP_OFS_DATA, 32'h01);
		chk("input buffers", 32'h03, {27'h0, pad.ie});
		drv_en <= 5'h00;
		wr(gfp_pkg::GFP_OFS_IE, 32'h0);
		$display("test direction done");
		wr(gfp_pkg::GFP_OFS_OD, 32'h1F);
		wr(gfp_pkg::GFP_OFS_OE, 32'h1F);
		wr(gfp_pkg::GFP_OFS_DATA, 32'h05);
		settle();
		chk("open drain pad", {22'h0, 5'h00, 5'h1A}, {22'h0, pad.o, pad.oe});
		wr(gfp_pkg::GFP_OFS_OD, 32'h0);
		settle();
		chk("push pull pad", {22'h0, 5'h05, 5'h1F}, {22'h0, pad.o, pad.oe});
		wr(gfp_pkg::GFP_OFS_OE, 32'h0);
		wr(gfp_pkg::GFP_OFS_PU, 32'h11);
		wr(gfp_pkg::GFP_OFS_PD, 32'h02);
		settle();
		chk("pull resistors", {22'h0, 5'h11, 5'h02}, {22'h0, pad.pu, pad.pd});
		wr(gfp_pkg::GFP_OFS_PU, 32'h0);
		wr(gfp_pkg::GFP_OFS_PD, 32'h0);
		$display("test pad controls done");
		// Alternate functions; the board never drives a pin that a function drives.
		wr(gfp_pkg::GFP_OFS_IE, 32'h1F);
		wr(gfp_pkg::GFP_OFS_OE, 32'h02);
		drv_en <= 5'h1D;
		drv_val <= 5'h15;
		per_from <= 4'h8;
		wr(gfp_pkg::GFP_OFS_FS1, 32'h1F);
		settle();
		chk("encoder and timer inputs", 32'h58, {25'h0, per_to});
		chk("timer output pin", 32'h1, {31'h0, pad.o[1]});
		wr(gfp_pkg::GFP_OFS_FS1, 32'h0);
		wr(gfp_pkg::GFP_OFS_OE, 32'h08);
		drv_en <= 5'h17;
		per_from <= 4'h4;
		wr(gfp_pkg::GFP_OFS_FS2, 32'h1C);
		settle();
		chk("serial inputs", 32'h06, {25'h0, per_to});
		chk("serial transmit pin", 32'h1, {31'h0, pad.o[3]});
		wr(gfp_pkg::GFP_OFS_FS2, 32'h18);
		wr(gfp_pkg::GFP_OFS_FS3, 32'h04);
		settle();
		chk("clear to send", 32'h05, {25'h0, per_to});
		$display("test functions done");
		test_done();
	end
endmodule : five_bit_gpio_port_with_boot_pin_tb_top

`default_nettype wire
